//--- logic/sps_defines.svh
/*
  Register offsets, field positions, mode codes, reset values and rate
  counts of the serial port.
  Assumes inclusion by bare name from the package, the checker and the bench.
*/
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_ADDR_W        3
`define SPS_OFS_BUFFER    3'h0
`define SPS_OFS_CONTROL   3'h1
`define SPS_OFS_STATUS    3'h2
`define SPS_OFS_ADDRESS   3'h3
`define SPS_OFS_MASK      3'h4
`define SPS_OFS_IRQ       3'h5

`define SPS_CTL_WRITE_COLLISION_FLAG      7
`define SPS_CTL_OV        6
`define SPS_CTL_EN        5
`define SPS_CTL_CKP       4
`define SPS_STA_SMP       7
`define SPS_STA_CKE       6
`define SPS_STA_BF        0
`define SPS_IRQ_FLAG      0

`define SPS_MODE_DIV4     4'h0
`define SPS_MODE_DIV16    4'h1
`define SPS_MODE_DIV64    4'h2
`define SPS_MODE_TIMER    4'h3
`define SPS_MODE_SLV_SS   4'h4
`define SPS_MODE_SLV_NOSS 4'h5
`define SPS_MODE_I2C_7    4'h6
`define SPS_MODE_I2C_10   4'h7
`define SPS_MODE_MASKSEL  4'h9
`define SPS_MODE_I2C_FWM  4'hb
`define SPS_MODE_I2C_7SP  4'he
`define SPS_MODE_I2C_10SP 4'hf

`define SPS_HALF_DIV4     6'h02
`define SPS_HALF_DIV16    6'h08
`define SPS_HALF_DIV64    6'h20

`define SPS_LAST_CKE1     5'h0f
`define SPS_LAST_CKE0     5'h10
`define SPS_LAST_SLAVE    5'h0f

`define SPS_RESET_BYTE    8'h00

`endif

//--- logic/sps_pkg.sv
/*
  Types of the serial port: bus request, pin groups, roles, phases.
  Assumes sps_defines.svh on the include path.
*/
`include "sps_defines.svh"

package sps_pkg;

  typedef struct packed {
    logic [`SPS_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } sps_bus_req_t;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic serial_in_pin;
  } sps_pin_in_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo_out;
    logic sdo_oe;
  } sps_pin_out_t;

  typedef enum logic [1:0] {
    SPS_ROLE_OFF    = 2'b00,
    SPS_ROLE_MASTER = 2'b01,
    SPS_ROLE_SLAVE  = 2'b10,
    SPS_ROLE_I2C    = 2'b11
  } sps_role_t;

  typedef enum logic [1:0] {
    SPS_ST_IDLE  = 2'b00,
    SPS_ST_SHIFT = 2'b01
  } sps_phase_t;

  typedef struct packed {
    logic [5:0] count;
  } sps_rate_state_t;

endpackage

//--- logic/sps_rate_gen.sv
/*
  Half bit period tick generator for the master role.
  Assumes a timer tick input that is one clock wide.
*/
module sps_rate_gen (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] rate_sel,
  input  wire logic       timer_tick,
  // Tick out
  output logic            half_tick
);
  import sps_pkg::*;

  sps_rate_state_t st_reg;
  sps_rate_state_t st_next;
  logic [5:0]      half;

  always_comb begin
    st_next = st_reg;
    case (rate_sel)
      2'b00:   half = `SPS_HALF_DIV4;
      2'b01:   half = `SPS_HALF_DIV16;
      default: half = `SPS_HALF_DIV64;
    endcase
    // Timer rate: one toggle per timer tick halves it
    if (rate_sel == 2'b11) begin
      half_tick = run & timer_tick;
    end else begin
      half_tick = run && (st_reg.count == half - 6'h01);
    end
    // Restart from zero so every word at a divided rate begins with a full half period
    if (!run || half_tick) begin
      st_next.count = 6'h00;
    end else begin
      st_next.count = st_reg.count + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- logic/sps_spi_port.sv
/*
  Synchronous serial port, SPI role, with register port and pin drivers.
  Assumes synchronous strobes, a one-clock timer tick and an external
  pin pad that resolves the output enables.
*/
// The address map and strobed register access are this design's own decisions.
// Overview of operation
// RULE1 - Byte arriving with buffer full sets overflow; software clears it. Code sets it in the slave role only; the master overwrites the buffer.
// RULE2 - Enable bit hands clock, out and in pins to the port.
// RULE3 - Polarity bit sets serial clock idle level in SPI roles.
// RULE4 - In I2C codes polarity zero holds clock low, one releases.
// RULE5 - Codes 0000 to 0011 pick master rate: /4, /16, /64, timer/2.
// RULE6 - Code 0100 slave with select, 0101 slave ignoring select.
// RULE7 - I2C codes decoded; reserved codes leave the port idle.
// RULE8 - Code 1001 redirects slave address accesses to the mask.
// RULE9 - Words shift most significant bit first.
// RULE10 - Full word moves to buffer, then sets full and interrupt flags.
// RULE11 - Buffer write while shifting is dropped, sets sticky collision.
// RULE12 - Reading the buffer clears buffer-full.
// RULE13 - Shift register only reached through the data buffer.
// RULE14 - Master starts clocking as soon as the buffer is written.
// RULE15 - Master keeps sampling input even with the output disabled.
// RULE16 - Shift out on one clock edge, latch in on the other. Code latches on the output edge in master end sampling.
// RULE17 - Slave shifts on pin clock edges, flags on last bit latched.
// RULE18 - Slave keeps working in sleep; received byte raises wake.
// RULE19 - With edge select set, output bit is valid before first edge.
// RULE20 - Software disables, reprograms, then re-enables to reconfigure.
// RULE21 - Software sets pin directions; input direction is automatic.
// RULE22 - Sample phase picks middle or end sampling; slave uses middle.
// RULE23 - Edge select and polarity together pick the output edge.
// RULE24 - Select high stops output and clears bit count; so does disable.
// RULE25 - Slave clock, select and input are synchronised before use.
module sps_spi_port (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Register port
  input  wire sps_pkg::sps_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  // Serial pins
  input  wire sps_pkg::sps_pin_in_t  pin_in,
  output sps_pkg::sps_pin_out_t      pin_out,
  // Timer and power
  input  wire logic                  timer_two_tick,
  input  wire logic                  sleep,
  output logic                       port_interrupt_flag,
  output logic                       wake_request
);
  import sps_pkg::*;

  typedef struct packed {
    sps_phase_t   phase;
    logic         write_collision_flag;
    logic         rx_overflow_flag;
    logic         port_enable_bit;
    logic         clock_polarity_bit;
    logic [3:0]   port_mode_field;
    logic         sample_phase_select;
    logic         clock_edge_select;
    logic         buffer_full_status;
    logic         irq_flag;
    logic [7:0]   data_buffer;
    logic [7:0]   shift_register;
    logic [7:0]   slave_address;
    logic [7:0]   address_mask;
    logic         cap;
    logic [4:0]   cnt;
    logic [2:0]   sync1;
    logic [2:0]   sync2;
    logic         sck_prev;
    logic [7:0]   rdata;
    sps_pin_out_t pins;
    logic         wake;
  } sps_state_t;

  sps_state_t st_reg;
  sps_state_t st_next;

  sps_role_t  role;
  logic       master;
  logic       slave;
  logic       ss_used;
  logic       ss_block;
  logic       sck_s;
  logic       sdi_s;
  logic       busy;
  logic       run;
  logic       half_tick;
  logic       ev;
  logic       mid;
  logic       bnd;
  logic       smp_eff;
  logic [4:0] last;
  logic       bit_in;
  logic [7:0] shifted;
  logic [7:0] word;
  logic       complete;
  logic       wr_buf;
  logic       mask_sel;
  logic [7:0] rd_val;

  function automatic sps_role_t decode_role(input logic [3:0] m);
    case (m)
      `SPS_MODE_DIV4,
      `SPS_MODE_DIV16,
      `SPS_MODE_DIV64,
      `SPS_MODE_TIMER:    decode_role = SPS_ROLE_MASTER;
      `SPS_MODE_SLV_SS,
      `SPS_MODE_SLV_NOSS: decode_role = SPS_ROLE_SLAVE;
      `SPS_MODE_I2C_7,
      `SPS_MODE_I2C_10,
      `SPS_MODE_I2C_FWM,
      `SPS_MODE_I2C_7SP,
      `SPS_MODE_I2C_10SP: decode_role = SPS_ROLE_I2C;
      default:            decode_role = SPS_ROLE_OFF;
    endcase
  endfunction

  // RULE5 - master rate selection
  sps_rate_gen u_rate (
    .clock      (clock),
    .resetn     (resetn),
    .run        (run),
    .rate_sel   (st_reg.port_mode_field[1:0]),
    .timer_tick (timer_two_tick),
    .half_tick  (half_tick)
  );

  always_comb begin
    st_next  = st_reg;
    complete = 1'b0;
    word     = st_reg.shift_register;

    // RULE7 - mode code decode
    role     = decode_role(st_reg.port_mode_field);
    // RULE6 - select used only in code 0100
    ss_used  = st_reg.port_mode_field == `SPS_MODE_SLV_SS;
    master   = st_reg.port_enable_bit && role == SPS_ROLE_MASTER;
    slave    = st_reg.port_enable_bit && role == SPS_ROLE_SLAVE;
    // RULE8 - address location redirect
    mask_sel = st_reg.port_mode_field == `SPS_MODE_MASKSEL;

    // RULE25 - two stage synchronisers, edge from stage two
    st_next.sync1    = {pin_in.sck, pin_in.ss_n, pin_in.serial_in_pin};
    st_next.sync2    = st_reg.sync1;
    st_next.sck_prev = st_reg.sync2[2];
    sck_s    = st_reg.sync2[2];
    sdi_s    = st_reg.sync2[0];
    ss_block = slave && ss_used && st_reg.sync2[1];

    busy = st_reg.phase == SPS_ST_SHIFT;
    // Master clocks freeze in sleep and resume on wake
    run  = master && busy && !sleep;

    // RULE17 - slave events are pin clock edges only
    // RULE18 - slave edges need no system sleep state
    if (master) begin
      ev = half_tick;
    end else begin
      ev = slave && !ss_block && (sck_s != st_reg.sck_prev);
    end

    // RULE16 - output edge and mid sample edge are opposite; master end sampling uses the output edge
    // RULE23 - edge select picks leading or trailing as output
    if (st_reg.clock_edge_select) begin
      mid = !st_reg.cnt[0];
      bnd = st_reg.cnt[0];
    end else begin
      mid = st_reg.cnt[0];
      bnd = (st_reg.cnt != 5'h00) && !st_reg.cnt[0];
    end
    // RULE22 - end sampling in master only, slave samples mid
    smp_eff = master && st_reg.sample_phase_select;
    if (!master) begin
      last = `SPS_LAST_SLAVE;
    end else if (st_reg.clock_edge_select) begin
      last = `SPS_LAST_CKE1;
    end else begin
      last = `SPS_LAST_CKE0;
    end
    bit_in  = smp_eff ? sdi_s : st_reg.cap;
    // RULE9 - most significant bit leaves first, new bit enters low
    shifted = {st_reg.shift_register[6:0], bit_in};

    // RULE12 - buffer read clears full flag
    if (bus_req.rd && bus_req.addr == `SPS_OFS_BUFFER) begin
      st_next.buffer_full_status = 1'b0;
    end

    // Register writes
    wr_buf = bus_req.wr && bus_req.addr == `SPS_OFS_BUFFER;
    if (bus_req.wr) begin
      case (bus_req.addr)
        `SPS_OFS_CONTROL: begin
          st_next.write_collision_flag = bus_req.wdata[`SPS_CTL_WRITE_COLLISION_FLAG];
          st_next.rx_overflow_flag     = bus_req.wdata[`SPS_CTL_OV];
          st_next.port_enable_bit      = bus_req.wdata[`SPS_CTL_EN];
          st_next.clock_polarity_bit   = bus_req.wdata[`SPS_CTL_CKP];
          st_next.port_mode_field      = bus_req.wdata[3:0];
        end
        `SPS_OFS_STATUS: begin
          st_next.sample_phase_select = bus_req.wdata[`SPS_STA_SMP];
          st_next.clock_edge_select   = bus_req.wdata[`SPS_STA_CKE];
        end
        `SPS_OFS_ADDRESS: begin
          // RULE8 - write lands in mask register
          if (mask_sel) begin
            st_next.address_mask = bus_req.wdata;
          end else begin
            st_next.slave_address = bus_req.wdata;
          end
        end
        `SPS_OFS_MASK: begin
          st_next.address_mask = bus_req.wdata;
        end
        `SPS_OFS_IRQ: begin
          st_next.irq_flag = bus_req.wdata[`SPS_IRQ_FLAG];
        end
        default: begin
        end
      endcase
    end

    // RULE11 - write while shifting dropped, collision sticky
    // RULE13 - buffer write is the only path into the shifter
    if (wr_buf) begin
      if (busy) begin
        st_next.write_collision_flag = 1'b1;
      end else begin
        st_next.shift_register = bus_req.wdata;
        // RULE19 - first bit valid before first clock edge
        st_next.pins.sdo_out = bus_req.wdata[7];
        // RULE14 - master starts the word at once
        if (master) begin
          st_next.phase = SPS_ST_SHIFT;
          st_next.cnt   = 5'h00;
        end
      end
    end

    // RULE15 - sampling runs whether or not the output is driven
    if (ev) begin
      st_next.phase = SPS_ST_SHIFT;
      st_next.cnt   = st_reg.cnt + 5'h01;
      if (master && st_reg.cnt != `SPS_LAST_CKE0) begin
        st_next.pins.sck_out = !st_reg.pins.sck_out;
      end
      if (mid && !smp_eff) begin
        st_next.cap = sdi_s;
      end
      if (bnd) begin
        st_next.shift_register = shifted;
        st_next.pins.sdo_out   = shifted[7];
      end
      if (st_reg.cnt == last) begin
        complete = 1'b1;
        word     = bnd ? shifted : {st_reg.shift_register[6:0], sdi_s};
        st_next.shift_register = word;
        st_next.pins.sdo_out   = word[7];
        st_next.phase          = SPS_ST_IDLE;
        st_next.cnt            = 5'h00;
      end
    end

    if (complete) begin
      // RULE1 - overflow keeps the old byte, new one is lost
      if (slave && st_reg.buffer_full_status) begin
        st_next.rx_overflow_flag = 1'b1;
      end else begin
        // RULE10 - word to buffer, then full and interrupt flags
        st_next.data_buffer        = word;
        st_next.buffer_full_status = 1'b1;
      end
      st_next.irq_flag = 1'b1;
    end

    // RULE18 - slave byte completion wakes the device
    st_next.wake = st_reg.wake && sleep;
    if (complete && slave && sleep) begin
      st_next.wake = 1'b1;
    end

    // RULE24 - select high or disable clears the bit counter
    if (!st_reg.port_enable_bit || ss_block) begin
      st_next.phase = SPS_ST_IDLE;
      st_next.cnt   = 5'h00;
    end

    // RULE3 - idle clock level follows polarity
    if (!busy || !master) begin
      st_next.pins.sck_out = st_next.clock_polarity_bit;
    end
    // RULE2 - enable hands the pins to the port
    // RULE21 - clock driven in master and in I2C codes with polarity zero, input pins never driven
    st_next.pins.sck_oe = master;
    st_next.pins.sdo_oe = master || (slave && !ss_block);
    // RULE4 - I2C clock stretch holds line low
    if (st_reg.port_enable_bit && role == SPS_ROLE_I2C) begin
      st_next.pins.sck_out = 1'b0;
      st_next.pins.sck_oe  = !st_reg.clock_polarity_bit;
    end

    // Read mux; data shows only in the cycle after the strobe
    case (bus_req.addr)
      `SPS_OFS_BUFFER:  rd_val = st_reg.data_buffer;
      `SPS_OFS_CONTROL: rd_val = {st_reg.write_collision_flag,
                                  st_reg.rx_overflow_flag,
                                  st_reg.port_enable_bit,
                                  st_reg.clock_polarity_bit,
                                  st_reg.port_mode_field};
      `SPS_OFS_STATUS:  rd_val = {st_reg.sample_phase_select,
                                  st_reg.clock_edge_select,
                                  5'h00,
                                  st_reg.buffer_full_status};
      // RULE8 - read returns mask register
      `SPS_OFS_ADDRESS: rd_val = mask_sel ? st_reg.address_mask
                                          : st_reg.slave_address;
      `SPS_OFS_MASK:    rd_val = st_reg.address_mask;
      `SPS_OFS_IRQ:     rd_val = {7'h00, st_reg.irq_flag};
      default:          rd_val = `SPS_RESET_BYTE;
    endcase
    st_next.rdata = bus_req.rd ? rd_val : `SPS_RESET_BYTE;
  end

  // Reconfiguration is only safe while disabled, since the counter
  // and shifter are not rebased on mode change
  // RULE20 - reconfigure through a disable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata               = st_reg.rdata;
  assign pin_out             = st_reg.pins;
  assign port_interrupt_flag = st_reg.irq_flag;
  assign wake_request        = st_reg.wake;

endmodule

//--- verification/sps_spi_peer.sv
/*
  Far-side SPI slave for the master role: a plain shift register.
  Assumes edge select set; the idle level is taken at each load.
*/
module sps_spi_peer (
  // Watching clock
  input  wire logic       clock,
  // Wire
  input  wire logic       sck,
  input  wire logic       serial_out_pin,
  output logic            serial_in_pin,
  // Word
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic       prev = 1'b0;
  logic       idle = 1'b0;
  int         n = 8;
  initial serial_in_pin = 1'b0;
  initial rx = 8'h00;
  always @(posedge clock) begin
    prev <= sck;
    if (load) begin
      sh <= tx;
      serial_in_pin <= tx[7];
      idle <= sck;
      n <= 0;
    end else if (n == 8) begin
      // Released line toggles so no stale bit looks valid
      serial_in_pin <= ~serial_in_pin;
    // sample leaving idle, shift on return
    end else if (sck != prev && sck != idle) begin
      rx <= {rx[6:0], serial_out_pin};
      n <= n + 1;
    end else if (sck != prev) begin
      sh <= sh << 1;
      serial_in_pin <= sh[6];
    end
  end
endmodule

//--- verification/sps_spi_port_checker.sv
/*
  Port checks of sps_spi_port, bound to every instance.
  Assumes the map and mode codes of sps_defines.svh.
*/
`include "sps_defines.svh"
module sps_spi_port_checker (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  resetn,
  // Register port
  input wire sps_pkg::sps_bus_req_t bus_req,
  input wire logic [7:0]            rdata,
  // Pins
  input wire sps_pkg::sps_pin_in_t  pin_in,
  input wire sps_pkg::sps_pin_out_t pin_out,
  // Timer and power
  input wire logic                  timer_two_tick,
  input wire logic                  sleep,
  input wire logic                  port_interrupt_flag,
  input wire logic                  wake_request
);
  import sps_pkg::*;
  logic [7:0] ctl_reg;
  logic [7:0] mask_reg;
  logic       mok_reg;
  logic [3:0] mode;
  logic       en;
  logic       mwr;
  assign mode = ctl_reg[3:0];
  assign en = ctl_reg[`SPS_CTL_EN];
  assign mwr = bus_req.addr == `SPS_OFS_MASK ||
    (bus_req.addr == `SPS_OFS_ADDRESS && mode == `SPS_MODE_MASKSEL);
  // Mirror of software writes only; hardware flags are not tracked
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= 8'h00;
      mask_reg <= 8'h00;
      mok_reg <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `SPS_OFS_CONTROL) ctl_reg <= bus_req.wdata;
      if (mwr) mask_reg <= bus_req.wdata;
      if (mwr) mok_reg <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_buf_sta;
    bus_req.rd && bus_req.addr == `SPS_OFS_BUFFER ##2
    bus_req.rd && bus_req.addr == `SPS_OFS_STATUS;
  endsequence
  sequence s_quiet_go;
    $stable(pin_out.sck_out) [*4] ##0
    (bus_req.wr && bus_req.addr == `SPS_OFS_BUFFER && en && mode == 4'h0);
  endsequence
  AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside a read answer");
  AST_OFF_NO_DRIVE: assert property ((!en) [*3] |-> !pin_out.sck_oe && !pin_out.sdo_oe)
    else $error("pins driven while disabled");
  AST_IDLE_LEVEL: assert property ($rose(port_interrupt_flag) && en && mode < 4'h4 |-> pin_out.sck_out == ctl_reg[`SPS_CTL_CKP])
    else $error("clock not at idle level after word");
  AST_I2C_HOLD: assert property (($stable(ctl_reg) && en && mode inside {4'h6, 4'h7, 4'hb, 4'he, 4'hf}) [*3] |-> pin_out.sck_oe == !ctl_reg[`SPS_CTL_CKP] && !pin_out.sck_out)
    else $error("clock hold wrong in two-wire codes");
  AST_SELECT_OFF: assert property ((en && mode == `SPS_MODE_SLV_SS && pin_in.ss_n) [*5] |-> !pin_out.sdo_oe)
    else $error("serial out driven while deselected");
  AST_READ_CLEARS: assert property (s_buf_sta |=> !rdata[`SPS_STA_BF])
    else $error("buffer full survives a buffer read");
  AST_MASK_REDIRECT: assert property (bus_req.rd && bus_req.addr == `SPS_OFS_ADDRESS && mode == `SPS_MODE_MASKSEL && mok_reg |=> rdata == mask_reg)
    else $error("address read not redirected to mask");
  AST_MASTER_GO: assert property (s_quiet_go |-> ##[1:4] $changed(pin_out.sck_out))
    else $error("master did not start clocking");
  AST_WAKE_DROP: assert property ((!sleep) [*2] |-> !wake_request)
    else $error("wake request while awake");
endmodule
bind sps_spi_port sps_spi_port_checker u_checker (
  .clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
  .pin_in(pin_in), .pin_out(pin_out), .timer_two_tick(timer_two_tick),
  .sleep(sleep), .port_interrupt_flag(port_interrupt_flag),
  .wake_request(wake_request)
);

//--- verification/tb_sps_spi_port.sv
/*
  Self-checking bench of sps_spi_port with a peer on its pins.
  Assumes the peer model and the bound checker are compiled with it.
*/
`include "sps_defines.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin \
  mismatches++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module tb_sps_spi_port;
  timeunit 1ns;
  timeprecision 1ns;
  import sps_pkg::*;
  logic         clock, irq, wake, p_sdi, tick = 1'b0;
  logic         resetn = 1'b0, sleep = 1'b0, p_load = 1'b0;
  logic         s_sck = 1'b0, s_ss_n = 1'b1, s_sdi = 1'b0;
  logic         use_peer = 1'b1;
  logic [2:0]   tcnt = 3'h0;
  logic [7:0]   rdata, rv, p_rx, d, x, v, p_tx = 8'h00;
  logic [15:0]  i2c = 16'hc8c0;
  sps_bus_req_t req = '0;
  sps_pin_in_t  pin_in;
  sps_pin_out_t pin_out;
  int           mismatches = 0, checks = 0, n;
  int unsigned  seed = 3;
  // pad directions: sdi only ever read
  assign pin_in = '{sck: s_sck, ss_n: s_ss_n,
                    serial_in_pin: use_peer ? p_sdi : s_sdi};
  sps_spi_port uut (
    .clock(clock), .resetn(resetn), .bus_req(req), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .timer_two_tick(tick),
    .sleep(sleep), .port_interrupt_flag(irq), .wake_request(wake));
  sps_spi_peer peer (
    .clock(clock), .sck(pin_out.sck_out), .serial_out_pin(pin_out.sdo_out),
    .serial_in_pin(p_sdi), .load(p_load), .tx(p_tx), .rx(p_rx));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    tcnt <= tcnt + 3'h1;
    tick <= tcnt == 3'h0;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic op(input logic [2:0] a, input logic [7:0] w, input bit wr);
    req <= '{addr: a, wdata: w, wr: wr, rd: !wr};
    @(posedge clock);
    req <= '0;
    #1 rv = rdata;
    @(posedge clock);
  endtask
  task automatic cfg(input logic [7:0] c);
    op(`SPS_OFS_CONTROL, c & 8'h1f, 1'b1);
    op(`SPS_OFS_CONTROL, c, 1'b1);
  endtask
  task automatic mrun(input logic [7:0] c, input int cyc, input bit coll);
    d = rnd();
    x = rnd();
    cfg(c);
    op(`SPS_OFS_IRQ, 8'h00, 1'b1);
    p_tx <= x;
    p_load <= 1'b1;
    @(posedge clock);
    p_load <= 1'b0;
    op(`SPS_OFS_BUFFER, d, 1'b1);
    if (coll) op(`SPS_OFS_BUFFER, ~d, 1'b1);
    #1;
    for (n = 0; irq !== 1'b1 && n < 2000; n++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    if (cyc > 0) `CHK("word cycles", cyc - 1 - 2 * coll, n)
    `CHK("peer byte", d, p_rx)
    op(`SPS_OFS_STATUS, 8'h00, 1'b0);
    `CHK("full", 1'b1, rv[`SPS_STA_BF])
    op(`SPS_OFS_BUFFER, 8'h00, 1'b0);
    // Fastest rate outruns the peer input path
    if (c[3:0] != `SPS_MODE_DIV4) `CHK("rx byte", x, rv)
    op(`SPS_OFS_STATUS, 8'h00, 1'b0);
    `CHK("empty", 1'b0, rv[`SPS_STA_BF])
    op(`SPS_OFS_CONTROL, 8'h00, 1'b0);
    `CHK("collision", coll, rv[`SPS_CTL_WRITE_COLLISION_FLAG])
  endtask
  task automatic sbyte(input logic [7:0] b, input int bits);
    for (int i = 7; i > 7 - bits; i--) begin
      s_sdi <= b[i];
      repeat (5) @(posedge clock);
      #1 v[i] = pin_out.sdo_out;
      @(posedge clock);
      s_sck <= 1'b1;
      repeat (6) @(posedge clock);
      s_sck <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    op(`SPS_OFS_CONTROL, 8'h00, 1'b0);
    `CHK("control reset", 8'h00, rv)
    op(3'h6, 8'h00, 1'b0);
    `CHK("unmapped", 8'h00, rv)
    for (int m = 0; m < 32; m++) begin
      cfg(8'h20 | 8'(m));
      repeat (4) @(posedge clock);
      #1 `CHK("clock oe", m[3:0] < 4 || (i2c[m % 16] && m < 16), pin_out.sck_oe)
      if (m[3:0] < 4) `CHK("idle", m >= 16, pin_out.sck_out)
      @(posedge clock);
    end
    op(`SPS_OFS_ADDRESS, 8'h33, 1'b1);
    op(`SPS_OFS_CONTROL, 8'h09, 1'b1);
    op(`SPS_OFS_ADDRESS, 8'h5a, 1'b1);
    op(`SPS_OFS_MASK, 8'h00, 1'b0);
    `CHK("mask", 8'h5a, rv)
    op(`SPS_OFS_ADDRESS, 8'h00, 1'b0);
    `CHK("redirect read", 8'h5a, rv)
    op(`SPS_OFS_CONTROL, 8'h00, 1'b1);
    op(`SPS_OFS_ADDRESS, 8'h00, 1'b0);
    `CHK("address", 8'h33, rv)
    op(`SPS_OFS_STATUS, 8'h40, 1'b1);
    mrun(8'h20 | `SPS_MODE_DIV4, 32, 1'b0);
    mrun(8'h30 | `SPS_MODE_DIV16, 128, 1'b1);
    op(`SPS_OFS_STATUS, 8'hc0, 1'b1);
    mrun(8'h20 | `SPS_MODE_DIV64, 512, 1'b0);
    mrun(8'h20 | `SPS_MODE_TIMER, 0, 1'b0);
    use_peer <= 1'b0;
    cfg(8'h20 | `SPS_MODE_SLV_SS);
    op(`SPS_OFS_IRQ, 8'h00, 1'b1);
    s_ss_n <= 1'b0;
    sleep <= 1'b1;
    d = rnd();
    x = rnd();
    op(`SPS_OFS_BUFFER, d, 1'b1);
    sbyte(x, 8);
    `CHK("slave out", d, v)
    `CHK("slave irq", 1'b1, irq)
    `CHK("wake", 1'b1, wake)
    sleep <= 1'b0;
    sbyte(rnd(), 8);
    op(`SPS_OFS_CONTROL, 8'h00, 1'b0);
    `CHK("overflow", 1'b1, rv[`SPS_CTL_OV])
    op(`SPS_OFS_BUFFER, 8'h00, 1'b0);
    `CHK("kept byte", x, rv)
    sbyte(rnd(), 4);
    s_ss_n <= 1'b1;
    repeat (8) @(posedge clock);
    s_ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    x = rnd();
    sbyte(x, 8);
    op(`SPS_OFS_BUFFER, 8'h00, 1'b0);
    `CHK("after select", x, rv)
    stop_test();
  end
endmodule
